/* File: logic/fwa_alert.sv */
// Status latching, warning compare, alert pin and alert response slave
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fwa_defs.svh"

module fwa_alert #(
    parameter int DW = 16,
    parameter int AW = 4,
    parameter logic [6:0] OWN_ADDR_RST = 7'h10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    // Analog fault and warning pins
    input wire logic uv_pin,
    input wire logic ov_pin,
    input wire logic oc_timeout_pin,
    input wire logic bus_error_pin,
    input wire logic reg_timer_pin,
    input wire logic fet_bad_pin,
    // Power monitor results
    input wire fwa_pkg::fwa_adc_t adc,
    // Hot swap output
    output logic hs_on,
    // SMBus link, data is open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Alert pin, open drain
    output logic alert_out,
    output logic alert_oe_n
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Strict compare, equality never trips
    function automatic logic above(input logic [11:0] v, input logic [11:0] lim);
        above = v > lim;
    endfunction

    // Positive current magnitude above mid code
    function automatic logic [10:0] cur_mag(input logic [11:0] c);
        cur_mag = c[11] ? c[10:0] : 11'h000;
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic scl_d;
    logic sda_d;
    wire logic [7:0] raw_in;
    assign raw_in = {fet_bad_pin, reg_timer_pin, bus_error_pin, oc_timeout_pin,
                     ov_pin, uv_pin, sda_in, scl_in};

    // Two stages before any use, one more copy for edge finding
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= 8'h03;
            sync2 <= 8'h03;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            scl_d <= sync2[0];
            sda_d <= sync2[1];
        end
    end

    wire logic scl_s;
    wire logic sda_s;
    wire logic uv_s;
    wire logic ov_s;
    wire logic oc_s;
    wire logic cml_s;
    wire logic regulation_timer_active_warning_s;
    wire logic fet_s;
    assign scl_s = sync2[0];
    assign sda_s = sync2[1];
    assign uv_s = sync2[2];
    assign ov_s = sync2[3];
    assign oc_s = sync2[4];
    assign cml_s = sync2[5];
    assign regulation_timer_active_warning_s = sync2[6];
    assign fet_s = sync2[7];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [2:0] ctrl;
    logic [`FWA_NST-1:0] mask;
    logic [11:0] vout_ov;
    logic [11:0] vout_uv;
    logic [11:0] iout_oc;
    logic [11:0] vin_ov;
    logic [11:0] vin_uv;
    logic [14:0] input_overpower_warning;
    logic [11:0] warn2;
    logic [6:0] own_addr;
    logic on_d;

    // Write strobes
    wire logic wr_ctrl;
    wire logic wr_clear;
    wire logic wr_mask;
    wire logic wr_lim;
    assign wr_ctrl = reg_wr && (reg_addr == `FWA_REG_CTRL);
    assign wr_clear = reg_wr && (reg_addr == `FWA_REG_CLEAR);
    assign wr_mask = reg_wr && (reg_addr == `FWA_REG_MASK);
    assign wr_lim = reg_wr;

    // Limits reset so that no ADC warning can trip
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= `FWA_CTRL_RST;
            mask <= `FWA_MASK_RST;
            vout_ov <= `FWA_LIM_MAX;
            vout_uv <= `FWA_LIM_MIN;
            iout_oc <= `FWA_LIM_MAX;
            vin_ov <= `FWA_LIM_MAX;
            vin_uv <= `FWA_LIM_MIN;
            input_overpower_warning <= `FWA_PWR_MAX;
            warn2 <= `FWA_LIM_MIN;
            own_addr <= OWN_ADDR_RST;
        end else if (wr_lim) begin
            if (wr_ctrl) ctrl <= reg_wdata[2:0];
            if (wr_mask) mask <= reg_wdata[`FWA_NST-1:0];
            if (reg_addr == `FWA_REG_VOUT_OV) vout_ov <= reg_wdata[11:0];
            if (reg_addr == `FWA_REG_VOUT_UV) vout_uv <= reg_wdata[11:0];
            if (reg_addr == `FWA_REG_IOUT_OC) iout_oc <= reg_wdata[11:0];
            if (reg_addr == `FWA_REG_VIN_OV) vin_ov <= reg_wdata[11:0];
            if (reg_addr == `FWA_REG_VIN_UV) vin_uv <= reg_wdata[11:0];
            if (reg_addr == `FWA_REG_INPUT_OVERPOWER_WARNING) input_overpower_warning <= reg_wdata[14:0];
            if (reg_addr == `FWA_REG_WARN2) warn2 <= reg_wdata[11:0];
            if (reg_addr == `FWA_REG_OWN_ADDR) own_addr <= reg_wdata[6:0];
        end
    end

    // ----------------------------------------------------------------
    // Hot swap output
    // ----------------------------------------------------------------
    logic oc_latch;
    wire logic on_cycle;
    wire logic fault_now;
    assign on_cycle = ctrl[`FWA_CTRL_ON] && !on_d;
    assign fault_now = uv_s || ov_s || oc_s;

    // Overcurrent timeout latches off until the output is cycled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            on_d <= 1'b1;
            oc_latch <= 1'b0;
            hs_on <= 1'b0;
        end else begin
            on_d <= ctrl[`FWA_CTRL_ON];
            if (oc_s) oc_latch <= 1'b1;
            else if (on_cycle) oc_latch <= 1'b0;
            hs_on <= ctrl[`FWA_CTRL_ON] && !fault_now && !oc_latch;
        end
    end

    // ----------------------------------------------------------------
    // Monitor compares
    // ----------------------------------------------------------------
    logic [11:0] vin_last;
    wire logic is_vin;
    wire logic is_vout;
    wire logic is_iout;
    wire logic [22:0] pwr;
    assign is_vin = adc.valid && (adc.chan == `FWA_CH_VIN);
    assign is_vout = adc.valid && (adc.chan == `FWA_CH_VOUT);
    assign is_iout = adc.valid && (adc.chan == `FWA_CH_IOUT);
    // Power uses the latest input voltage, only forward current counts
    assign pwr = vin_last * cur_mag(adc.code);

    // Keep last input voltage for the power product
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vin_last <= `FWA_LIM_MIN;
        end else if (is_vin) begin
            vin_last <= adc.code;
        end
    end

    // ----------------------------------------------------------------
    // Status set events and present conditions
    // ----------------------------------------------------------------
    wire logic [`FWA_NST-1:0] set_ev;
    wire logic [`FWA_NST-1:0] cond;
    wire logic w2_hit;
    assign w2_hit = ctrl[`FWA_CTRL_W2_UNDER] ? above(warn2, adc.code)
                                             : above(adc.code, warn2);
    // Faults are unconditional, no enable gates them
    assign set_ev[`FWA_ST_UV] = uv_s;
    assign set_ev[`FWA_ST_OV] = ov_s;
    assign set_ev[`FWA_ST_OC] = oc_s;
    // Warnings only touch status, never the output
    assign set_ev[`FWA_ST_CML] = cml_s;
    assign set_ev[`FWA_ST_REGULATION_TIMER_ACTIVE_WARNING] = regulation_timer_active_warning_s;
    assign set_ev[`FWA_ST_IOUT_OC] = is_iout && above(adc.code, iout_oc);
    assign set_ev[`FWA_ST_WARN2] = is_iout && w2_hit;
    assign set_ev[`FWA_ST_VIN_UV] = is_vin && above(vin_uv, adc.code);
    assign set_ev[`FWA_ST_VIN_OV] = is_vin && above(adc.code, vin_ov);
    assign set_ev[`FWA_ST_VOUT_UV] = is_vout && above(vout_uv, adc.code);
    assign set_ev[`FWA_ST_VOUT_OV] = is_vout && above(adc.code, vout_ov);
    assign set_ev[`FWA_ST_INPUT_OVERPOWER_WARNING] = is_iout && (pwr[22:8] > input_overpower_warning);
    assign set_ev[`FWA_ST_FET_BAD] = fet_s;
    // Monitor warnings hold no level, so a clear drops them until next sample
    assign cond = {fet_s, 7'h00, regulation_timer_active_warning_s, 1'b0, oc_s, ov_s, uv_s};

    // ----------------------------------------------------------------
    // Status latch and alert state
    // ----------------------------------------------------------------
    logic [`FWA_NST-1:0] status;
    logic alert_active;
    logic ara_won;
    wire logic clr_all;
    wire logic new_alert;
    wire logic [`FWA_NST-1:0] next_status;
    assign clr_all = wr_clear || on_cycle;
    // Set wins over clear, a clear never drops a present condition
    assign next_status = set_ev | (status & ~({`FWA_NST{clr_all}} & ~cond));
    assign new_alert = |(set_ev & ~status & mask);
    // Open drain pull: active low, or pull when idle if inverted
    wire logic pull_low;
    assign pull_low = alert_active ^ ctrl[`FWA_CTRL_INV];

    // Latch status, track alert, drive the pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status <= {`FWA_NST{1'b0}};
            alert_active <= 1'b0;
            alert_out <= 1'b0;
            alert_oe_n <= 1'b1;
        end else begin
            status <= next_status;
            if (new_alert) alert_active <= 1'b1;
            else if (clr_all || ara_won) alert_active <= 1'b0;
            alert_out <= 1'b0;
            alert_oe_n <= !pull_low;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    logic [DW-1:0] rd_mux;
    always_comb begin
        rd_mux = {DW{1'b0}};
        if (reg_addr == `FWA_REG_CTRL) rd_mux[2:0] = ctrl;
        else if (reg_addr == `FWA_REG_STATUS) rd_mux[`FWA_NST-1:0] = status;
        else if (reg_addr == `FWA_REG_MASK) rd_mux[`FWA_NST-1:0] = mask;
        else if (reg_addr == `FWA_REG_VOUT_OV) rd_mux[11:0] = vout_ov;
        else if (reg_addr == `FWA_REG_VOUT_UV) rd_mux[11:0] = vout_uv;
        else if (reg_addr == `FWA_REG_IOUT_OC) rd_mux[11:0] = iout_oc;
        else if (reg_addr == `FWA_REG_VIN_OV) rd_mux[11:0] = vin_ov;
        else if (reg_addr == `FWA_REG_VIN_UV) rd_mux[11:0] = vin_uv;
        else if (reg_addr == `FWA_REG_INPUT_OVERPOWER_WARNING) rd_mux[14:0] = input_overpower_warning;
        else if (reg_addr == `FWA_REG_WARN2) rd_mux[11:0] = warn2;
        else if (reg_addr == `FWA_REG_OWN_ADDR) rd_mux[6:0] = own_addr;
    end

    // Data stands one cycle only, zero otherwise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) reg_rdata <= {DW{1'b0}};
        else reg_rdata <= reg_rd ? rd_mux : {DW{1'b0}};
    end

    // ----------------------------------------------------------------
    // Alert response slave
    // ----------------------------------------------------------------
    fwa_pkg::fwa_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] txreg;
    wire logic scl_rise;
    wire logic scl_fall;
    wire logic bus_start;
    wire logic bus_stop;
    wire logic ara_hit;
    wire logic arb_lost;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign bus_start = scl_s && scl_d && sda_d && !sda_s;
    assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
    // Read to the response address, answered only while alerting
    assign ara_hit = (shreg[7:1] == `FWA_ARA) && shreg[0] && alert_active;
    // Released one seen low: a lower address owns the bus
    assign arb_lost = scl_rise && txreg[7] && !sda_s;

    // Sda is driven late after scl falls; 8 samples per link bit give margin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= fwa_pkg::FWA_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            txreg <= 8'h00;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            ara_won <= 1'b0;
        end else begin
            ara_won <= 1'b0;
            if (bus_start) begin
                state <= fwa_pkg::FWA_ADDR;
                cnt <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (bus_stop) begin
                state <= fwa_pkg::FWA_IDLE;
                sda_oe_n <= 1'b1;
            end else begin
                case (state)
                    fwa_pkg::FWA_ADDR: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_s};
                            cnt <= cnt + 4'h1;
                        end else if (scl_fall && cnt == `FWA_BITS) begin
                            if (ara_hit) begin
                                state <= fwa_pkg::FWA_ACK;
                                sda_oe_n <= 1'b0;
                                txreg <= {own_addr, 1'b1};
                            end else begin
                                state <= fwa_pkg::FWA_IDLE;
                            end
                        end
                    end
                    fwa_pkg::FWA_ACK: begin
                        if (scl_fall) begin
                            state <= fwa_pkg::FWA_DATA;
                            cnt <= 4'h0;
                            sda_oe_n <= txreg[7];
                        end
                    end
                    fwa_pkg::FWA_DATA: begin
                        if (arb_lost) begin
                            // Alert stays set; the next read tries again
                            state <= fwa_pkg::FWA_IDLE;
                            sda_oe_n <= 1'b1;
                        end else if (scl_rise) begin
                            cnt <= cnt + 4'h1;
                        end else if (scl_fall && cnt == `FWA_BITS) begin
                            state <= fwa_pkg::FWA_NACK;
                            sda_oe_n <= 1'b1;
                        end else if (scl_fall) begin
                            txreg <= {txreg[6:0], 1'b0};
                            sda_oe_n <= txreg[6];
                        end
                    end
                    fwa_pkg::FWA_NACK: begin
                        if (scl_rise) begin
                            ara_won <= 1'b1;
                            state <= fwa_pkg::FWA_IDLE;
                        end
                    end
                    default: begin
                        state <= fwa_pkg::FWA_IDLE;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* File: logic/fwa_defs.svh */
// Offsets, bit positions, reset values and constants of the alert block
`ifndef FWA_DEFS_SVH
`define FWA_DEFS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define FWA_REG_CTRL 4'h0
`define FWA_REG_CLEAR 4'h1
`define FWA_REG_STATUS 4'h2
`define FWA_REG_MASK 4'h3
`define FWA_REG_VOUT_OV 4'h4
`define FWA_REG_VOUT_UV 4'h5
`define FWA_REG_IOUT_OC 4'h6
`define FWA_REG_VIN_OV 4'h7
`define FWA_REG_VIN_UV 4'h8
`define FWA_REG_INPUT_OVERPOWER_WARNING 4'h9
`define FWA_REG_WARN2 4'hA
`define FWA_REG_OWN_ADDR 4'hB

// ----------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------
`define FWA_CTRL_ON 0
`define FWA_CTRL_INV 1
`define FWA_CTRL_W2_UNDER 2
`define FWA_CTRL_RST 3'h5

// ----------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------
`define FWA_NST 13
`define FWA_ST_UV 0
`define FWA_ST_OV 1
`define FWA_ST_OC 2
`define FWA_ST_CML 3
`define FWA_ST_REGULATION_TIMER_ACTIVE_WARNING 4
`define FWA_ST_IOUT_OC 5
`define FWA_ST_WARN2 6
`define FWA_ST_VIN_UV 7
`define FWA_ST_VIN_OV 8
`define FWA_ST_VOUT_UV 9
`define FWA_ST_VOUT_OV 10
`define FWA_ST_INPUT_OVERPOWER_WARNING 11
`define FWA_ST_FET_BAD 12
`define FWA_MASK_RST 13'h1000

// ----------------------------------------------------------------
// Reset values, codes and link constants
// ----------------------------------------------------------------
`define FWA_LIM_MAX 12'hFFF
`define FWA_LIM_MIN 12'h000
`define FWA_PWR_MAX 15'h7FFF
`define FWA_CUR_MID 12'h800
`define FWA_ARA 7'h0C
`define FWA_BITS 4'h8
`define FWA_CH_VIN 2'h0
`define FWA_CH_VOUT 2'h1
`define FWA_CH_IOUT 2'h2

`endif

/* File: logic/fwa_pkg.sv */
// Types shared by the fault, warning and alert block
`default_nettype none
package fwa_pkg;

    // One ADC result from the power monitor
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [11:0] code;
    } fwa_adc_t;

    // Alert response slave states
    typedef enum logic [2:0] {
        FWA_IDLE = 3'b000,
        FWA_ADDR = 3'b001,
        FWA_ACK = 3'b010,
        FWA_DATA = 3'b011,
        FWA_NACK = 3'b100
    } fwa_state_t;

endpackage
`default_nettype wire

/* File: testbench/fwa_alert_chk.sv */
// Concurrent checks on the pins of the alert block
`timescale 1ns/100ps
`default_nettype none
`include "fwa_defs.svh"
module fwa_alert_chk #(
    parameter int AW = 4
) (
    // Clock, reset, bus
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [AW-1:0] reg_addr,
    input wire logic reg_wr,
    // Fault, warning and monitor inputs
    input wire logic uv_pin,
    input wire logic ov_pin,
    input wire logic oc_timeout_pin,
    input wire logic bus_error_pin,
    input wire logic reg_timer_pin,
    input wire logic fet_bad_pin,
    input wire fwa_pkg::fwa_adc_t adc,
    // Watched outputs
    input wire logic hs_on,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic alert_out,
    input wire logic alert_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Cycles since a legal cause; saturates so idle stretches never wrap
    logic [3:0] since_off;
    logic [3:0] since_set;
    wire logic flt = uv_pin | ov_pin | oc_timeout_pin;
    wire logic pin = flt | bus_error_pin | reg_timer_pin | fet_bad_pin;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            since_off <= 4'hF;
            since_set <= 4'hF;
        end else begin
            since_off <= (flt | reg_wr) ? 4'h0 : since_off + {3'h0, since_off != 4'hF};
            since_set <= (pin | adc.valid | reg_wr) ? 4'h0 : since_set + {3'h0, since_set != 4'hF};
        end
    end
    sequence s_quiet_clear;
        reg_wr && reg_addr == `FWA_REG_CLEAR && !pin && !adc.valid ##1 !pin && !adc.valid;
    endsequence
    property p_rst_rel; $rose(reset_n) |-> alert_oe_n && sda_oe_n; endproperty
    property p_uv_off; uv_pin [*3] |-> ##[0:1] !hs_on; endproperty
    property p_ov_off; ov_pin [*4] |-> !hs_on; endproperty
    property p_oc_off; oc_timeout_pin [*3] |=> !hs_on [*2]; endproperty
    property p_warn_keep; $fell(hs_on) |-> since_off <= 4'h4; endproperty
    property p_alert_cause; $fell(alert_oe_n) |-> since_set <= 4'h5; endproperty
    property p_clear_rel; s_quiet_clear |=> ##[0:1] alert_oe_n; endproperty
    property p_sda_alert; !sda_oe_n |-> !alert_oe_n; endproperty
    property p_open_drain; reset_n |-> !alert_out && !sda_out; endproperty
    a_rst_rel: assert property (p_rst_rel)
        else $error("pins not released after reset");
    a_uv_off: assert property (p_uv_off)
        else $error("output on during undervoltage");
    a_ov_off: assert property (p_ov_off)
        else $error("output on during overvoltage");
    a_oc_off: assert property (p_oc_off)
        else $error("output on after overcurrent timeout");
    a_warn_keep: assert property (p_warn_keep)
        else $error("output switched off without a fault");
    a_alert_cause: assert property (p_alert_cause)
        else $error("alert asserted without a new event");
    a_clear_rel: assert property (p_clear_rel)
        else $error("alert held after clear");
    a_sda_alert: assert property (p_sda_alert)
        else $error("alert response without alert");
    a_open_drain: assert property (p_open_drain)
        else $error("open drain pin driven high");
endmodule
`default_nettype wire

/* File: testbench/fwa_host.sv */
// Bus host model issuing alert response reads
`timescale 1ns/100ps
`default_nettype none
module fwa_host (
    // Link pins
    output logic scl,
    output logic sda_pull,
    input wire logic sda_wire
);
    localparam int Q = 100;
    // Clock idles high between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // One bit: data moves while clock low, read in the middle of high phase
    task automatic slot(input logic low, output logic seen);
        scl = 1'b0;
        #Q;
        sda_pull = low;
        #Q;
        scl = 1'b1;
        #Q;
        seen = sda_wire;
        #Q;
    endtask
    // Rival pulls data low as a lower-addressed responder would
    task automatic ara(input logic rival, output logic [7:0] d, output logic ack_n);
        logic [7:0] hdr;
        logic s;
        hdr = {7'h0C, 1'b1};
        sda_pull = 1'b1;
        #(2 * Q);
        for (int i = 7; i >= 0; i--) slot(!hdr[i], s);
        slot(1'b0, ack_n);
        for (int i = 7; i >= 0; i--) slot(rival, d[i]);
        slot(1'b0, s);
        scl = 1'b0;
        #Q;
        sda_pull = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sda_pull = 1'b0;
        #(2 * Q);
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench of the fault, warning and alert block
`timescale 1ns/100ps
`default_nettype none
`include "fwa_defs.svh"
module tb;
    // ----------------------------------------
    // Stimulus, wires and instances
    // ----------------------------------------
    logic clk, reset_n, reg_wr, reg_rd, hs_on, scl, sda_pull, sda_out, sda_oe_n;
    logic alert_out, alert_oe_n;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [5:0] pins;
    fwa_pkg::fwa_adc_t adc;
    int n_fail, comparisons;
    // Both lines have pull-ups
    wire logic sda_wire = !sda_pull && (sda_oe_n || sda_out);
    wire logic alert_wire = alert_oe_n || alert_out;
    fwa_alert i_fwa_alert (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .uv_pin(pins[0]), .ov_pin(pins[1]), .oc_timeout_pin(pins[2]),
        .bus_error_pin(pins[3]), .reg_timer_pin(pins[4]), .fet_bad_pin(pins[5]),
        .adc(adc), .hs_on(hs_on), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
    fwa_host i_fwa_host (.scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check({15'h0, got}, {15'h0, exp});
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    task automatic sample(input logic [1:0] ch, input logic [11:0] c);
        @(posedge clk);
        adc <= '{valid: 1'b1, chan: ch, code: c};
        @(posedge clk);
        adc.valid <= 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(`FWA_REG_CTRL, 16'h0005);
        rd(`FWA_REG_MASK, 16'h1000);
        rd(`FWA_REG_VOUT_OV, 16'h0FFF);
        rd(`FWA_REG_INPUT_OVERPOWER_WARNING, 16'h7FFF);
        wr(`FWA_REG_STATUS, 16'hFFFF);
        rd(4'hF, 16'h0000);
        sample(`FWA_CH_VIN, 12'h000);
        sample(`FWA_CH_VOUT, 12'hFFF);
        sample(`FWA_CH_IOUT, 12'hFFF);
        rd(`FWA_REG_STATUS, 16'h0000);
        chk1(alert_wire, 1'b1);
    endtask
    // Each fault and pin warning; overcurrent and regulation timer exits use the output off-on path
    task automatic t_pins;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            pins[i] <= 1'b1;
            waitc(6);
            chk1(hs_on, i > 2);
            chk1(alert_wire, i < 5);
            rd(`FWA_REG_STATUS, (i < 5) ? 16'h1 << i : 16'h1000);
            wr(`FWA_REG_CLEAR, 16'h0000);
            rd(`FWA_REG_STATUS, (i < 5) ? 16'h1 << i : 16'h1000);
            @(posedge clk);
            pins[i] <= 1'b0;
            waitc(4);
            if (i == 2 || i == 4) begin
                wr(`FWA_REG_CTRL, 16'h0004);
                wr(`FWA_REG_CTRL, 16'h0005);
            end else begin
                wr(`FWA_REG_CLEAR, 16'h0000);
            end
            rd(`FWA_REG_STATUS, 16'h0000);
            waitc(3);
            chk1(hs_on, 1'b1);
            chk1(alert_wire, 1'b1);
        end
    endtask
    task automatic t_vout;
        wr(`FWA_REG_MASK, 16'h0200);
        wr(`FWA_REG_VOUT_UV, 16'h0100);
        sample(`FWA_CH_VOUT, 12'h100);
        rd(`FWA_REG_STATUS, 16'h0000);
        sample(`FWA_CH_VOUT, 12'h0FF);
        waitc(3);
        chk1(alert_wire, 1'b0);
        chk1(hs_on, 1'b1);
        wr(`FWA_REG_CLEAR, 16'h0000);
        waitc(3);
        chk1(alert_wire, 1'b1);
        sample(`FWA_CH_VOUT, 12'h0FF);
        waitc(3);
        chk1(alert_wire, 1'b0);
    endtask
    task automatic t_ara;
        logic [7:0] d;
        logic ack_n;
        i_fwa_host.ara(1'b1, d, ack_n);
        check({8'h0, d}, 16'h0000);
        chk1(alert_wire, 1'b0);
        i_fwa_host.ara(1'b0, d, ack_n);
        chk1(ack_n, 1'b0);
        check({9'h0, d[7:1]}, 16'h0010);
        chk1(alert_wire, 1'b1);
        sample(`FWA_CH_VOUT, 12'h0FF);
        waitc(3);
        chk1(alert_wire, 1'b1);
        rd(`FWA_REG_STATUS, 16'h0200);
        i_fwa_host.ara(1'b0, d, ack_n);
        chk1(ack_n, 1'b1);
        wr(`FWA_REG_CLEAR, 16'h0000);
        rd(`FWA_REG_STATUS, 16'h0000);
    endtask
    // Other compares: equal never trips for input low, output high, current and power; one past trips; then inverted level
    task automatic t_mon;
        wr(`FWA_REG_VIN_UV, 16'h0200);
        wr(`FWA_REG_VIN_OV, 16'h0C00);
        wr(`FWA_REG_VOUT_OV, 16'h0C00);
        wr(`FWA_REG_IOUT_OC, 16'h0A00);
        wr(`FWA_REG_INPUT_OVERPOWER_WARNING, 16'h0400);
        wr(`FWA_REG_WARN2, 16'h0900);
        sample(`FWA_CH_VIN, 12'h200);
        sample(`FWA_CH_VOUT, 12'hC00);
        sample(`FWA_CH_IOUT, 12'hA00);
        rd(`FWA_REG_STATUS, 16'h0000);
        wr(`FWA_REG_CTRL, 16'h0001);
        sample(`FWA_CH_VIN, 12'h1FF);
        sample(`FWA_CH_VIN, 12'hC01);
        sample(`FWA_CH_VOUT, 12'hC01);
        sample(`FWA_CH_IOUT, 12'hA01);
        rd(`FWA_REG_STATUS, 16'h0DE0);
        wr(`FWA_REG_CTRL, 16'h0003);
        waitc(2);
        chk1(alert_wire, 1'b0);
        sample(`FWA_CH_VOUT, 12'h0FF);
        waitc(3);
        chk1(alert_wire, 1'b1);
    endtask
    task automatic summarize;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        pins = 6'h00;
        adc = '0;
        n_fail = 0;
        comparisons = 0;
        waitc(5);
        reset_n <= 1'b1;
        t_reset();
        t_pins();
        t_vout();
        t_ara();
        t_mon();
        summarize();
    end
    // Hang guard
    initial begin
        #2000000;
        n_fail++;
        summarize();
    end
endmodule
bind fwa_alert fwa_alert_chk #(.AW(AW)) i_fwa_alert_chk (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .uv_pin(uv_pin), .ov_pin(ov_pin),
    .oc_timeout_pin(oc_timeout_pin), .bus_error_pin(bus_error_pin),
    .reg_timer_pin(reg_timer_pin), .fet_bad_pin(fet_bad_pin), .adc(adc), .hs_on(hs_on),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
`default_nettype wire
